// ---- core_regs_pkg.sv ----
// core register set constants: offsets, reset values, field positions
// assumes one 50 MHz clock and a core that issues one access at a time
package core_regs_pkg;

	// ****************************************************************
	// offsets as printed, the low seven bits select the register
	// ****************************************************************
	localparam logic [11:0] OFS_INDIRECT_PORT_ZERO         = 12'h0F80;
	localparam logic [11:0] OFS_INDIRECT_PORT_ONE          = 12'h0F81;
	localparam logic [11:0] OFS_PROGRAM_COUNTER_LOW        = 12'h0F82;
	localparam logic [11:0] OFS_CORE_FLAGS                 = 12'h0F83;
	localparam logic [11:0] OFS_POINTER_ZERO_LOW           = 12'h0F84;
	localparam logic [11:0] OFS_POINTER_ZERO_HIGH          = 12'h0F85;
	localparam logic [11:0] OFS_POINTER_ONE_LOW            = 12'h0F86;
	localparam logic [11:0] OFS_POINTER_ONE_HIGH           = 12'h0F87;
	localparam logic [11:0] OFS_BANK_SELECTOR              = 12'h0F88;
	localparam logic [11:0] OFS_WORKING_ACCUMULATOR        = 12'h0F89;
	localparam logic [11:0] OFS_PROGRAM_COUNTER_HIGH_LATCH = 12'h0F8A;
	localparam logic [11:0] OFS_INTERRUPT_CONTROL          = 12'h0F8B;
	// last unimplemented location of the bank-local core range
	localparam logic [11:0] OFS_CORE_RANGE_END             = 12'h0F9F;
	// mask that folds every bank and all four quarters onto one location
	localparam logic [6:0]  MIRROR_MASK                    = 7'h1F;

	// ****************************************************************
	// widths and reset values
	// ****************************************************************
	localparam int          PC_WIDTH         = 15;
	localparam int          PC_LATCH_WIDTH   = 7;
	localparam int          BANK_WIDTH       = 5;
	localparam int          FLAGS_WIDTH      = 5;
	localparam logic [4:0]  FLAGS_RST_POR    = 5'h18;
	localparam logic [7:0]  BYTE_ZERO        = 8'h00;
	localparam logic [14:0] PC_RST           = 15'h0000;
	localparam logic [6:0]  PC_LATCH_RST     = 7'h00;
	localparam logic [4:0]  BANK_RST         = 5'h00;

	// ****************************************************************
	// core flag field positions
	// ****************************************************************
	localparam int FLAG_TIMEOUT    = 4;
	localparam int FLAG_POWER_DOWN = 3;
	localparam int FLAG_ZERO       = 2;
	localparam int FLAG_DIGIT      = 1;
	localparam int FLAG_CARRY      = 0;
	localparam int ARITH_MSB       = 2;

	// indirect access sequencer
	typedef enum logic {
		IND_IDLE,
		IND_ISSUE
	} ind_state_t;

endpackage : core_regs_pkg

// ---- pointer_pair.sv ----
// one indirect pointer pair: low and high address bytes
// assumes por_bor and rst are synchronous to core_clk
`timescale 1ns/1ps
module pointer_pair import core_regs_pkg::*; (
	// clock and resets
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       por_bor,
	// byte writes
	input  wire logic       lo_we,
	input  wire logic       hi_we,
	input  wire logic [7:0] wdata,
	// contents
	output logic      [7:0] ptr_lo,
	output logic      [7:0] ptr_hi
);

	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
	} ptr_st_t;

	ptr_st_t st_q;
	ptr_st_t st_d;

	// ****************************************************************
	// next state
	// ****************************************************************
	// low byte survives a plain reset, high byte never does
	always_comb begin
		st_d = st_q;
		if (lo_we) begin
			st_d.lo = wdata;
		end
		if (hi_we) begin
			st_d.hi = wdata;
		end
		if (por_bor) begin
			st_d.lo = BYTE_ZERO;
			st_d.hi = BYTE_ZERO;
		end else if (rst) begin
			st_d.lo = st_q.lo;
			st_d.hi = BYTE_ZERO;
		end
	end

	always_ff @(posedge core_clk) begin
		st_q <= st_d;
	end

	assign ptr_lo = st_q.lo;
	assign ptr_hi = st_q.hi;

endmodule : pointer_pair

// ---- core_banked_register_mirror.sv ----
// core register set mirrored into every data bank, with two indirect ports
// assumes the core waits while busy is high and memory answers in the mem_rd cycle
`timescale 1ns/1ps

module core_banked_register_mirror import core_regs_pkg::*; (
	// clock and resets
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      por_bor,
	input  wire logic                      rst_timeout_val,
	input  wire logic                      rst_power_down_val,
	// core access port
	input  wire logic [6:0]                acc_ofs,
	input  wire logic                      acc_rd,
	input  wire logic                      acc_wr,
	input  wire logic [7:0]                acc_wdata,
	output logic                           acc_hit,
	output logic                           busy,
	output logic      [7:0]                rdata,
	output logic                           rd_valid,
	// core execution hooks
	input  wire logic                      pc_inc,
	input  wire logic                      arith_we,
	input  wire logic [2:0]                arith_flags,
	output logic      [PC_WIDTH-1:0]       pc,
	output logic      [BANK_WIDTH-1:0]     bank,
	output logic      [7:0]                accumulator,
	output logic      [7:0]                intr_ctrl,
	// data memory port for indirect access
	output logic      [15:0]               mem_addr,
	output logic                           mem_rd,
	output logic                           mem_wr,
	output logic      [7:0]                mem_wdata,
	input  wire logic [7:0]                mem_rdata
);

	// ****************************************************************
	// state
	// ****************************************************************
	// one packed record holds every flip-flop of the block; the pointer
	// pairs live in their own instances because their reset split differs
	typedef struct packed {
		logic [PC_WIDTH-1:0]       pc;
		logic [PC_LATCH_WIDTH-1:0] pc_latch;
		logic [FLAGS_WIDTH-1:0]    flags;
		logic [BANK_WIDTH-1:0]     bank;
		logic [7:0]                working_accumulator;
		logic [7:0]                interrupt_control;
		logic [7:0]                rdata;
		logic                      rd_valid;
		ind_state_t                ind;
		logic [15:0]               mem_addr;
		logic [7:0]                mem_wdata;
		logic                      mem_rd;
		logic                      mem_wr;
	} core_st_t;

	core_st_t st_q;
	core_st_t st_d;

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	// folded map of the core set, identical in every bank:
	//   0x00  first indirect port, no storage
	//   0x01  second indirect port, no storage
	//   0x02  program counter low byte
	//   0x03  flags, timeout and power-down in bits 4:3
	//   0x04  first pointer low byte
	//   0x05  first pointer high byte
	//   0x06  second pointer low byte
	//   0x07  second pointer high byte
	//   0x08  bank selector, five bits
	//   0x09  working accumulator
	//   0x0a  program counter high latch, seven bits
	//   0x0b  interrupt control
	//   0x0c..0x1f  unimplemented, read zero
	// every register offset constant is folded before it is compared, so the
	// printed full addresses can stay in the package as they are
	// the mask drops the two upper offset bits that select the bank quarter
	// fold an offset onto its mirrored location
	function automatic logic [6:0] fold(input logic [6:0] ofs);
		fold = ofs & MIRROR_MASK;
	endfunction : fold

	// true when the folded offset equals a printed register offset
	function automatic logic hits(input logic [6:0] ofs, input logic [11:0] reg_ofs);
		hits = (fold(ofs) == fold(reg_ofs[6:0]));
	endfunction : hits

	// pointer contents and access qualifiers
	logic [7:0] p0_lo;
	logic [7:0] p0_hi;
	logic [7:0] p1_lo;
	logic [7:0] p1_hi;
	logic       take_rd;
	logic       take_wr;
	logic       in_range;
	logic [7:0] direct_rd;

	// ****************************************************************
	// access qualification
	// ****************************************************************
	// the core set occupies the first thirty-two offsets of every bank, so
	// the bank bits never enter the decode; offsets above that range belong
	// to other registers and are left for them to answer
	// one access at a time; requests during busy are dropped, the core must
	// watch busy rather than retry blindly, since nothing is queued here
	assign in_range = (acc_ofs <= OFS_CORE_RANGE_END[6:0]);
	assign acc_hit  = in_range;
	assign busy     = (st_q.ind != IND_IDLE);
	assign take_rd  = acc_rd && acc_hit && !busy && in_range;
	assign take_wr  = acc_wr && acc_hit && !busy && in_range;

	// ****************************************************************
	// pointer pairs
	// ****************************************************************
	// both pairs share one module; only their write strobes differ
	pointer_pair u_ptr_zero (
		.core_clk (core_clk),
		.rst      (rst),
		.por_bor  (por_bor),
		.lo_we    (take_wr && hits(acc_ofs, OFS_POINTER_ZERO_LOW)),
		.hi_we    (take_wr && hits(acc_ofs, OFS_POINTER_ZERO_HIGH)),
		.wdata    (acc_wdata),
		.ptr_lo   (p0_lo),
		.ptr_hi   (p0_hi)
	);

	pointer_pair u_ptr_one (
		.core_clk (core_clk),
		.rst      (rst),
		.por_bor  (por_bor),
		.lo_we    (take_wr && hits(acc_ofs, OFS_POINTER_ONE_LOW)),
		.hi_we    (take_wr && hits(acc_ofs, OFS_POINTER_ONE_HIGH)),
		.wdata    (acc_wdata),
		.ptr_lo   (p1_lo),
		.ptr_hi   (p1_hi)
	);

	// ****************************************************************
	// direct read multiplexer
	// ****************************************************************
	// anything not named below, including 0x0c..0x1f, reads zero
	// decoded from the live offset, registered only when a read is taken
	always_comb begin
		direct_rd = BYTE_ZERO;
		if (hits(acc_ofs, OFS_PROGRAM_COUNTER_LOW)) begin
			direct_rd = st_q.pc[7:0];
		end else if (hits(acc_ofs, OFS_CORE_FLAGS)) begin
			direct_rd = {3'b000, st_q.flags};
		end else if (hits(acc_ofs, OFS_POINTER_ZERO_LOW)) begin
			direct_rd = p0_lo;
		end else if (hits(acc_ofs, OFS_POINTER_ZERO_HIGH)) begin
			direct_rd = p0_hi;
		end else if (hits(acc_ofs, OFS_POINTER_ONE_LOW)) begin
			direct_rd = p1_lo;
		end else if (hits(acc_ofs, OFS_POINTER_ONE_HIGH)) begin
			direct_rd = p1_hi;
		end else if (hits(acc_ofs, OFS_BANK_SELECTOR)) begin
			direct_rd = {3'b000, st_q.bank};
		end else if (hits(acc_ofs, OFS_WORKING_ACCUMULATOR)) begin
			direct_rd = st_q.working_accumulator;
		end else if (hits(acc_ofs, OFS_PROGRAM_COUNTER_HIGH_LATCH)) begin
			direct_rd = {1'b0, st_q.pc_latch};
		end else if (hits(acc_ofs, OFS_INTERRUPT_CONTROL)) begin
			direct_rd = st_q.interrupt_control;
		end
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	// order of the blocks matters: steps first, then accesses, then resets,
	// so a later block wins over an earlier one in the same cycle
	always_comb begin
		st_d          = st_q;
		st_d.rd_valid = 1'b0;
		st_d.mem_rd   = 1'b0;
		st_d.mem_wr   = 1'b0;
		// program counter steps unless the low byte is written
		if (pc_inc) begin
			st_d.pc = st_q.pc + 15'h0001;
		end
		if (arith_we) begin
			st_d.flags[ARITH_MSB:0] = arith_flags;
		end
		// indirect answer: memory data is valid in the mem_rd cycle
		// the memory must answer within that cycle, there is no wait state
		if (st_q.ind == IND_ISSUE) begin
			st_d.ind = IND_IDLE;
			if (st_q.mem_rd) begin
				st_d.rdata    = mem_rdata;
				st_d.rd_valid = 1'b1;
			end
		end
		// indirect ports own no storage, they launch a memory access
		if ((take_rd || take_wr) && hits(acc_ofs, OFS_INDIRECT_PORT_ZERO)) begin
			st_d.ind       = IND_ISSUE;
			st_d.mem_addr  = {p0_hi, p0_lo};
			st_d.mem_wdata = acc_wdata;
			st_d.mem_rd    = take_rd;
			st_d.mem_wr    = take_wr;
		end else if ((take_rd || take_wr) && hits(acc_ofs, OFS_INDIRECT_PORT_ONE)) begin
			st_d.ind       = IND_ISSUE;
			st_d.mem_addr  = {p1_hi, p1_lo};
			st_d.mem_wdata = acc_wdata;
			st_d.mem_rd    = take_rd;
			st_d.mem_wr    = take_wr;
		end else if (take_rd) begin
			st_d.rdata    = direct_rd;
			st_d.rd_valid = 1'b1;
		end
		// direct writes; unimplemented locations fall through untouched
		if (take_wr) begin
			case (fold(acc_ofs))
				fold(OFS_PROGRAM_COUNTER_LOW[6:0]): begin
					st_d.pc = {st_q.pc_latch, acc_wdata};
				end
				fold(OFS_CORE_FLAGS[6:0]): begin
					// timeout and power-down are hardware owned
					st_d.flags[ARITH_MSB:0] = acc_wdata[ARITH_MSB:0];
				end
				fold(OFS_BANK_SELECTOR[6:0]): begin
					st_d.bank = acc_wdata[BANK_WIDTH-1:0];
				end
				fold(OFS_WORKING_ACCUMULATOR[6:0]): begin
					st_d.working_accumulator = acc_wdata;
				end
				fold(OFS_PROGRAM_COUNTER_HIGH_LATCH[6:0]): begin
					st_d.pc_latch = acc_wdata[PC_LATCH_WIDTH-1:0];
				end
				fold(OFS_INTERRUPT_CONTROL[6:0]): begin
					st_d.interrupt_control = acc_wdata;
				end
				default: begin
					// unimplemented or storage-free location drops the write; pointer bytes are stored in their own instances
					st_d.interrupt_control = st_d.interrupt_control;
				end
			endcase
		end
		// resets last so they override every access in the same cycle
		// pointer bytes are reset inside their own instances
		if (por_bor || rst) begin
			st_d.pc        = PC_RST;
			st_d.pc_latch  = PC_LATCH_RST;
			st_d.bank      = BANK_RST;
			st_d.interrupt_control    = BYTE_ZERO;
			st_d.rdata     = BYTE_ZERO;
			st_d.rd_valid  = 1'b0;
			st_d.ind       = IND_IDLE;
			st_d.mem_addr  = 16'h0000;
			st_d.mem_wdata = BYTE_ZERO;
			st_d.mem_rd    = 1'b0;
			st_d.mem_wr    = 1'b0;
		end
		// power-on clears what a plain reset keeps
		if (por_bor) begin
			st_d.flags = FLAGS_RST_POR;
			st_d.working_accumulator  = BYTE_ZERO;
		end else if (rst) begin
			// arithmetic flags and accumulator hold across a plain reset
			st_d.flags                  = st_q.flags;
			st_d.flags[FLAG_TIMEOUT]    = rst_timeout_val;
			st_d.flags[FLAG_POWER_DOWN] = rst_power_down_val;
			st_d.working_accumulator                   = st_q.working_accumulator;
		end
	end

	// single register stage for the whole record; every reset is
	// synchronous, so the reset decisions all live in the comb block above
	always_ff @(posedge core_clk) begin
		st_q <= st_d;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// data outputs come straight from flip-flops, only acc_hit and busy are comb
	assign rdata       = st_q.rdata;
	assign rd_valid    = st_q.rd_valid;
	assign pc          = st_q.pc;
	assign bank        = st_q.bank;
	assign accumulator = st_q.working_accumulator;
	assign intr_ctrl   = st_q.interrupt_control;
	assign mem_addr    = st_q.mem_addr;
	assign mem_rd      = st_q.mem_rd;
	assign mem_wr      = st_q.mem_wr;
	assign mem_wdata   = st_q.mem_wdata;

endmodule : core_banked_register_mirror

// ---- core_mirror_properties.sv ----
// checker for the core register set: access timing, indirect ports, resets
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module core_mirror_properties import core_regs_pkg::*; (
	// clock and resets
	input wire logic                  core_clk,
	input wire logic                  rst,
	input wire logic                  por_bor,
	// access port
	input wire logic [6:0]            acc_ofs,
	input wire logic                  acc_rd,
	input wire logic                  acc_wr,
	input wire logic [7:0]            acc_wdata,
	input wire logic                  busy,
	input wire logic [7:0]            rdata,
	input wire logic                  rd_valid,
	// execution hooks and memory
	input wire logic                  pc_inc,
	input wire logic [PC_WIDTH-1:0]   pc,
	input wire logic [BANK_WIDTH-1:0] bank,
	input wire logic [7:0]            accumulator,
	input wire logic [7:0]            intr_ctrl,
	input wire logic                  mem_rd,
	input wire logic                  mem_wr,
	input wire logic [7:0]            mem_wdata,
	input wire logic [7:0]            mem_rdata
);
	// ****************************************************************
	// helpers and sequences
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst || por_bor);
	// a request only counts when idle and inside the core range
	wire take = !busy && (acc_ofs < 7'h20);
	sequence ind_issue;
		mem_rd && busy;
	endsequence
	sequence ind_answer;
		rd_valid && (rdata == $past(mem_rdata));
	endsequence

	// ****************************************************************
	// assertions
	// ****************************************************************
	chk_direct_rd_lat: assert property (acc_rd && take && acc_ofs > 7'h01 |=> rd_valid)
		else $error("direct read answer missing");
	chk_ind_rd_seq: assert property (acc_rd && take && acc_ofs < 7'h02 |=> ind_issue ##1 ind_answer)
		else $error("indirect read sequence wrong");
	chk_ind_wr_issue: assert property (acc_wr && take && acc_ofs < 7'h02 |=> mem_wr && busy && mem_wdata == $past(acc_wdata))
		else $error("indirect write not issued");
	chk_unimpl_zero: assert property (acc_rd && take && acc_ofs >= 7'h0C |=> rdata == 8'h00)
		else $error("unimplemented location not zero");
	chk_busy_single: assert property (busy |=> !busy)
		else $error("busy longer than one cycle");
	chk_pc_load: assert property (acc_wr && take && acc_ofs == 7'h02 |=> pc[7:0] == $past(acc_wdata))
		else $error("pc low write lost");
	chk_pc_step: assert property (pc_inc && !(acc_wr && acc_ofs == 7'h02) |=> pc == $past(pc) + 15'h0001)
		else $error("pc step wrong");
	chk_acc_load: assert property (acc_wr && take && acc_ofs == 7'h09 |=> accumulator == $past(acc_wdata))
		else $error("accumulator write lost");
	chk_por_clear: assert property (disable iff (1'b0) por_bor |=> pc == 15'h0000 && bank == 5'h00 && accumulator == 8'h00 && intr_ctrl == 8'h00)
		else $error("power-on values wrong");
	chk_rst_keep: assert property (disable iff (1'b0) rst && !por_bor |=> pc == 15'h0000 && bank == 5'h00 && intr_ctrl == 8'h00 && accumulator == $past(accumulator))
		else $error("plain reset values wrong");
endmodule : core_mirror_properties

bind core_banked_register_mirror core_mirror_properties chk_inst (.core_clk, .rst, .por_bor, .acc_ofs, .acc_rd, .acc_wr,
	.acc_wdata, .busy, .rdata, .rd_valid, .pc_inc, .pc, .bank, .accumulator, .intr_ctrl, .mem_rd, .mem_wr, .mem_wdata,
	.mem_rdata);

// ---- data_mem_model.sv ----
// data memory behind the indirect ports
// assumes reads are answered combinationally in the mem_rd cycle
`timescale 1ns/1ps
module data_mem_model (
	// clock
	input wire logic        core_clk,
	// memory port
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_wdata,
	output logic     [7:0]  mem_rdata
);
	// ****************************************************************
	// storage
	// ****************************************************************
	logic [7:0] store [0:65535];
	logic [7:0] last_q = 8'h5A;
	// outside a read the bus shows the inverse, so a stale sample fails
	assign mem_rdata = mem_rd ? store[mem_addr] : ~last_q;
	always_ff @(posedge core_clk) begin
		if (mem_wr) store[mem_addr] <= mem_wdata;
		if (mem_rd) last_q <= mem_rdata;
	end
endmodule : data_mem_model

// ---- testbench.sv ----
// testbench: core register set exercised through its access port
// assumes the memory model stands on the data memory port
`timescale 1ns/1ps
module testbench import core_regs_pkg::*;;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic                  core_clk = 1'b0;
	logic                  rst, por_bor, rst_timeout_val, rst_power_down_val;
	logic                  acc_rd, acc_wr, pc_inc, arith_we, acc_hit, busy, rd_valid, mem_rd, mem_wr;
	logic [6:0]            acc_ofs;
	logic [2:0]            arith_flags;
	logic [7:0]            acc_wdata, rdata, mem_rdata, mem_wdata, intr_ctrl, accumulator;
	logic [PC_WIDTH-1:0]   pc;
	logic [BANK_WIDTH-1:0] bank;
	logic [15:0]           mem_addr;
	int                    error_cnt, checks_done, i;

	always #10 core_clk = ~core_clk;
	core_banked_register_mirror core_banked_register_mirror_inst (.core_clk, .rst, .por_bor, .rst_timeout_val,
		.rst_power_down_val, .acc_ofs, .acc_rd, .acc_wr, .acc_wdata, .acc_hit, .busy, .rdata, .rd_valid, .pc_inc,
		.arith_we, .arith_flags, .pc, .bank, .accumulator, .intr_ctrl, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
	data_mem_model data_mem_model_inst (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic check(input logic [23:0] g, input logic [23:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : check
	// an idle cycle after each write keeps the strobe from toggling twice
	task automatic reg_wr(input logic [6:0] o, input logic [7:0] d);
		acc_ofs = o;
		acc_wdata = d;
		acc_wr = 1'b1;
		@(posedge core_clk);
		#1;
		acc_wr = 1'b0;
		@(posedge core_clk);
		#1;
	endtask : reg_wr
	task automatic rd_chk(input logic [6:0] o, input logic [7:0] e);
		int n;
		acc_ofs = o;
		acc_rd = 1'b1;
		@(posedge core_clk);
		#1;
		acc_rd = 1'b0;
		for (n = 0; n < 3 && rd_valid !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		check(rd_valid, 1'b1);
		check(rdata, e);
		// one idle edge so a following request never re-raises the strobe in the same step
		@(posedge core_clk);
		#1;
	endtask : rd_chk
	task automatic do_reset(input logic p);
		por_bor = p;
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		por_bor = 1'b0;
		rst = 1'b0;
	endtask : do_reset
	task automatic pulse_step(input logic inc, input logic we);
		pc_inc = inc;
		arith_we = we;
		@(posedge core_clk);
		#1;
		pc_inc = 1'b0;
		arith_we = 1'b0;
	endtask : pulse_step
	task automatic wrap_up();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// ****************************************************************
	// tests
	// ****************************************************************
	// watchdog sized well above the two hundred or so cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		{acc_rd, acc_wr, pc_inc, arith_we} = 4'h0;
		{acc_ofs, acc_wdata, arith_flags} = 18'h0_0000;
		{rst_timeout_val, rst_power_down_val} = 2'b10;
		do_reset(1'b1);
		check(pc, 16'h0000);
		check({bank, accumulator, intr_ctrl}, 16'h0000);
		rd_chk(7'h03, 8'h18);
		for (i = 2; i < 12; i++) if (i != 3) rd_chk(i[6:0], 8'h00);
		// registers 0x04..0x0b written, then read back through their widths
		for (i = 4; i < 12; i++) reg_wr(i[6:0], 8'hA0 + i[7:0]);
		for (i = 4; i < 12; i++) rd_chk(i[6:0], i == 8 ? 8'h08 : i == 10 ? 8'h2A : 8'hA0 + i[7:0]);
		check({bank, accumulator}, {8'h08, 8'hA9});
		reg_wr(7'h03, 8'hFF);
		rd_chk(7'h03, 8'h1F);
		for (i = 12; i < 32; i++) begin
			reg_wr(i[6:0], 8'hFF);
			check(acc_hit, 1'b1);
			rd_chk(i[6:0], 8'h00);
		end
		// an offset past the core range is not ours and must be dropped
		reg_wr(7'h69, 8'h55);
		check(acc_hit, 1'b0);
		rd_chk(7'h09, 8'hA9);
		// indirect ports reach memory through the pointer pairs
		reg_wr(7'h00, 8'h5C);
		check(mem_addr, 16'hA5A4);
		reg_wr(7'h01, 8'hC3);
		check(mem_addr, 16'hA7A6);
		check(mem_wdata, 8'hC3);
		rd_chk(7'h00, 8'h5C);
		rd_chk(7'h01, 8'hC3);
		// program counter load from latch, then one step
		reg_wr(7'h02, 8'h9E);
		check(pc, 15'h2A9E);
		pulse_step(1'b1, 1'b0);
		rd_chk(7'h02, 8'h9F);
		arith_flags = 3'b101;
		pulse_step(1'b0, 1'b1);
		rd_chk(7'h03, 8'h1D);
		// plain reset keeps the pointer low bytes and arithmetic flags
		rst_timeout_val = 1'b0;
		rst_power_down_val = 1'b1;
		do_reset(1'b0);
		check({pc[7:0], bank, 3'b000}, 16'h0000);
		check(accumulator, 8'hA9);
		rd_chk(7'h03, 8'h0D);
		rd_chk(7'h04, 8'hA4);
		rd_chk(7'h05, 8'h00);
		rd_chk(7'h06, 8'hA6);
		rd_chk(7'h07, 8'h00);
		rd_chk(7'h0A, 8'h00);
		do_reset(1'b1);
		check(accumulator, 8'h00);
		rd_chk(7'h06, 8'h00);
		rd_chk(7'h03, 8'h18);
		wrap_up();
	end
endmodule : testbench
